// File: inc/pg_seq_pkg.sv
// shared constants and types for the power-good sequencer
package pg_seq_pkg;
	localparam int unsigned NUM_OUTPUTS = 4;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned INTERVAL_W = 24;
	// default stage delay in microseconds, as a cycle count
	localparam int unsigned STAGE_DELAY_US = 100;
	localparam logic [INTERVAL_W-1:0] STAGE_DELAY_CYCLES =
		INTERVAL_W'(STAGE_DELAY_US * CLK_MHZ);
	localparam logic [NUM_OUTPUTS-1:0] OUT_RESET = 4'hf;
	localparam logic [NUM_OUTPUTS-1:0] OE_RESET = 4'hf;

	// start conditions from the supervisory side
	typedef struct packed {
		logic gate_full;      // gate drive at full level
		logic drain_low;      // drain monitor below threshold
		logic fault_clear;    // fault clear asserted (active high here)
		logic forced_shutdown_n;
		logic shutdown_timer_done;
		logic card_detect_1_n;
		logic card_detect_2_n;
		logic card_detect_req;
	} start_cond_t;

	typedef struct packed {
		logic chain_enable_a;
		logic chain_enable_b;
		logic chain_enable_c;
	} chain_en_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RUN
	} seq_state_t;
endpackage : pg_seq_pkg

// File: rtl/sync_2ff.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic ref_clk,  // system clock
	input wire logic rst,      // synchronous reset
	input wire logic [W-1:0] d, // asynchronous level
	output logic [W-1:0] q     // synchronised level
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// next values
	always_comb begin
		meta_nxt = rst ? INIT : d;
		q_nxt = rst ? INIT : meta_r;
	end

	// registers
	always_ff @(posedge ref_clk) begin
		meta_r <= meta_nxt;
		q <= q_nxt;
	end
endmodule : sync_2ff
`default_nettype wire

// File: rtl/stage_timer.sv
// reloadable down counter that measures one stage delay
`timescale 1ns/1ns
`default_nettype none
module stage_timer
	import pg_seq_pkg::*;
(
	input wire logic ref_clk,  // system clock
	input wire logic rst,      // synchronous reset
	input wire logic start,    // restart the interval
	input wire logic hold,     // stop and clear
	input wire logic [pg_seq_pkg::INTERVAL_W-1:0] interval, // cycles
	output logic done          // one-cycle pulse at expiry
);
	logic [INTERVAL_W-1:0] cnt_r;
	logic [INTERVAL_W-1:0] cnt_nxt;
	logic run_r;
	logic run_nxt;
	logic done_nxt;

	// count down from the interval, pulse at the last cycle
	always_comb begin
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		done_nxt = 1'b0;
		if (rst || hold) begin
			cnt_nxt = '0;
			run_nxt = 1'b0;
		end else if (start) begin
			cnt_nxt = (interval == '0) ? INTERVAL_W'(1) : interval;
			run_nxt = 1'b1;
		end else if (run_r) begin
			if (cnt_r <= INTERVAL_W'(1)) begin
				run_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - INTERVAL_W'(1);
			end
		end
	end

	// registers
	always_ff @(posedge ref_clk) begin
		cnt_r <= cnt_nxt;
		run_r <= run_nxt;
		done <= done_nxt;
	end
endmodule : stage_timer
`default_nettype wire

// File: rtl/power_good_sequencer.sv
// four-stage open-drain power-good sequencer with cascaded enables
// Contract
// - first output asserts at once when conditions hold
// - later outputs follow predecessor by stage delay
// - enable a low releases outputs two to four
// - enable a high: output two after delay
// - enable b low releases outputs three, four
// - enable b high: output three after delay
// - enable c low releases output four
// - enable c high: output four after delay
// - outputs open-drain, active low, no pull-up
// - unconnected enables read as high
// - lower enable overrides all later stages
// - fault clear releases all outputs
// - forced shutdown after timer kills everything
// - optional card detect gating of start
`timescale 1ns/1ns
`default_nettype none
module power_good_sequencer
	import pg_seq_pkg::*;
(
	input wire logic ref_clk,  // 125 MHz system clock
	input wire logic rst,      // synchronous reset, active high
	input wire pg_seq_pkg::start_cond_t start_in, // supervisory pins
	input wire pg_seq_pkg::chain_en_t chain_in,   // chain enable pins
	input wire logic [pg_seq_pkg::INTERVAL_W-1:0] stage_delay, // cycles
	output logic gate_drive,        // gate drive enable
	output logic supply_ok_1_n,     // pin output value, always low
	output logic supply_ok_2_n,     // pin output value, always low
	output logic supply_ok_3_n,     // pin output value, always low
	output logic supply_ok_4_n,     // pin output value, always low
	output logic [3:0] supply_ok_oe_n, // low drives pin n+1 low
	output logic [3:0] seq_state    // asserted stages, bit 0 first
);
	start_cond_t st_s;
	chain_en_t ch_s;
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [NUM_OUTPUTS-1:0] on_r;
	logic [NUM_OUTPUTS-1:0] on_nxt;
	logic [NUM_OUTPUTS-1:0] allow;
	logic [NUM_OUTPUTS-1:0] allow_r; // enables as seen one cycle ago
	logic start_ok;
	logic shut;
	logic timer_start;
	logic timer_done;
	logic [1:0] stage_r;
	logic [1:0] stage_nxt;
	logic gate_nxt;
	logic [3:0] oe_n_nxt;

	// pins pass two flip-flops before use
	sync_2ff #(.W($bits(start_cond_t)), .INIT('0)) u_sync_start (
		.ref_clk(ref_clk),
		.rst(rst),
		.d(start_in),
		.q(st_s)
	);

	sync_2ff #(.W($bits(chain_en_t)), .INIT('1)) u_sync_chain (
		.ref_clk(ref_clk),
		.rst(rst),
		.d(chain_in),
		.q(ch_s)
	);

	stage_timer u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(timer_start),
		.hold(~start_ok),
		.interval(stage_delay),
		.done(timer_done)
	);

	// shutdown and card detect gating of the start conditions
	always_comb begin
		shut = ~st_s.forced_shutdown_n & st_s.shutdown_timer_done;
		// gate full and drain below threshold
		start_ok = st_s.gate_full & st_s.drain_low;
		start_ok = start_ok & ~st_s.fault_clear & ~shut;
		if (st_s.card_detect_req)
			start_ok = start_ok & ~st_s.card_detect_1_n &
				~st_s.card_detect_2_n;
	end

	// cascade: each enable covers all later stages
	always_comb begin
		allow[0] = 1'b1;
		// enable a gates stages two to four
		allow[1] = ch_s.chain_enable_a;
		// enable b gates stages three, four
		allow[2] = ch_s.chain_enable_a & ch_s.chain_enable_b;
		allow[3] = allow[2] & ch_s.chain_enable_c;
	end

	// sequence state and stage outputs
	always_comb begin
		state_nxt = state_r;
		on_nxt = on_r & allow;
		stage_nxt = stage_r;
		timer_start = 1'b0;
		unique case (state_r)
			SEQ_IDLE: begin
				on_nxt = '0;
				stage_nxt = 2'h0;
				if (start_ok) begin
					on_nxt = 4'h1;
					state_nxt = SEQ_RUN;
					timer_start = allow[1];
				end
			end
			SEQ_RUN: begin
				if (!start_ok) begin
					// release all, restart at stage one
					on_nxt = '0;
					state_nxt = SEQ_IDLE;
				end else begin
					// step to next stage on delay expiry
					if (timer_done && allow[stage_r + 2'h1] &&
						stage_r != 2'h3) begin
						on_nxt[stage_r + 2'h1] = 1'b1;
						stage_nxt = stage_r + 2'h1;
					end
					// a released stage rewinds the chain to the last stage still allowed
					if (!allow[stage_r]) begin
						if (!allow[1])
							stage_nxt = 2'h0;
						else if (!allow[2])
							stage_nxt = 2'h1;
						else
							stage_nxt = 2'h2;
					end
					// re-arm delay when next stage held
					// a restored enable restarts the delay too, else
					// the idle timer would leave the chain stuck
					if (stage_nxt != 2'h3 && allow[stage_nxt + 2'h1] &&
						!on_nxt[stage_nxt + 2'h1] &&
						(stage_nxt != stage_r || timer_done ||
						!allow_r[stage_nxt + 2'h1] ||
						!allow[stage_r + 2'h1] ||
						!on_r[stage_nxt]))
						timer_start = 1'b1;
				end
			end
		endcase
		if (rst) begin
			state_nxt = SEQ_IDLE;
			on_nxt = '0;
			stage_nxt = 2'h0;
		end
	end

	// open drain: drive low when on, else float
	always_comb begin
		gate_nxt = start_ok & ~rst;
		oe_n_nxt = rst ? OE_RESET : ~on_nxt;
	end

	// registers
	always_ff @(posedge ref_clk) begin
		state_r <= state_nxt;
		on_r <= on_nxt;
		stage_r <= stage_nxt;
		allow_r <= rst ? '1 : allow;
		gate_drive <= gate_nxt;
		supply_ok_oe_n <= oe_n_nxt;
		seq_state <= on_nxt;
		supply_ok_1_n <= 1'b0;
		supply_ok_2_n <= 1'b0;
		supply_ok_3_n <= 1'b0;
		supply_ok_4_n <= 1'b0;
	end
endmodule : power_good_sequencer
`default_nettype wire

// File: test/pg_seq_sva.sv
// assertion checker for the power-good sequencer
`timescale 1ns/1ns
`default_nettype none
module pg_seq_chk
	import pg_seq_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire pg_seq_pkg::start_cond_t start_in, // start pins
	input wire pg_seq_pkg::chain_en_t chain_in, // enables
	input wire logic gate_drive, // gate
	input wire logic [3:0] supply_ok_oe_n // low drives line
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence gone_s; (!start_in.gate_full)[*4]; endsequence
	sequence fs_s;
		(!start_in.forced_shutdown_n && start_in.shutdown_timer_done)[*4];
	endsequence
	AST_FIRST: assert property (gate_drive == !supply_ok_oe_n[0])
		else $error("gate and first stage differ");
	AST_LAG: assert property ($fell(supply_ok_oe_n[1]) |->
		$past(!supply_ok_oe_n[0], 2)) else $error("stage two early");
	AST_ORD: assert property (!supply_ok_oe_n[3] |->
		supply_ok_oe_n[2:0] == 3'h0) else $error("stage order");
	AST_ENA: assert property ((!chain_in.chain_enable_a)[*4] |->
		&supply_ok_oe_n[3:1]) else $error("enable a ignored");
	AST_ENB: assert property ((!chain_in.chain_enable_b)[*4] |->
		&supply_ok_oe_n[3:2]) else $error("enable b ignored");
	AST_ENC: assert property ((!chain_in.chain_enable_c)[*4] |->
		supply_ok_oe_n[3]) else $error("enable c ignored");
	AST_FLT: assert property (start_in.fault_clear[*4] |->
		supply_ok_oe_n == 4'hf && !gate_drive) else $error("fault clear");
	AST_FS: assert property (fs_s |-> !gate_drive &&
		supply_ok_oe_n == 4'hf) else $error("forced shutdown ignored");
	AST_LOST: assert property (gone_s |-> supply_ok_oe_n == 4'hf)
		else $error("lost start kept stages");
endmodule : pg_seq_chk
`default_nettype wire

// File: test/pg_load.sv
// converter enable lines, pulled up outside the sequencer
`timescale 1ns/1ns
`default_nettype none
module pg_load (
	input wire logic [3:0] drv, // drive values
	input wire logic [3:0] oe_n, // low pulls line
	output logic [3:0] line // line levels
);
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			line[i] = oe_n[i] ? 1'b1 : drv[i];
		end
	end
endmodule : pg_load
`default_nettype wire

// File: test/test_power_good_sequencer.sv
// self-checking bench for the power-good sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
	fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_power_good_sequencer;
	import pg_seq_pkg::*;
	localparam int D = 4;
	logic ref_clk = 0;
	logic rst = 1;
	start_cond_t start_in = '0;
	chain_en_t chain_in = '1;
	logic gate_drive;
	logic [3:0] drv, oe_n, st, line, e;
	int fail_count = 0;
	int checks = 0;
	int n, ok;
	logic [31:0] seed = 32'h00007b05;
	power_good_sequencer power_good_sequencer_i (.ref_clk(ref_clk),
		.rst(rst), .start_in(start_in), .chain_in(chain_in),
		.stage_delay(24'h4), .gate_drive(gate_drive),
		.supply_ok_1_n(drv[0]), .supply_ok_2_n(drv[1]),
		.supply_ok_3_n(drv[2]), .supply_ok_4_n(drv[3]),
		.supply_ok_oe_n(oe_n), .seq_state(st));
	pg_load pg_load_i (.drv(drv), .oe_n(oe_n), .line(line));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// settle, then compare against the reference model
	task automatic settle_check();
		repeat (4 * D + 12) @(negedge ref_clk);
		ok = start_in.gate_full && start_in.drain_low;
		ok = ok && !start_in.fault_clear;
		ok = ok && !(!start_in.forced_shutdown_n && start_in.shutdown_timer_done);
		ok = ok && !(start_in.card_detect_req && (start_in.card_detect_1_n
			|| start_in.card_detect_2_n));
		e[0] = (ok != 0);
		e[1] = e[0] && chain_in.chain_enable_a;
		e[2] = e[1] && chain_in.chain_enable_b;
		e[3] = e[2] && chain_in.chain_enable_c;
		`CHK("gate", e[0], gate_drive)
		`CHK("oe", ~e, oe_n)
		`CHK("state", e, st)
		`CHK("line", ~e, line)
	endtask : settle_check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		#(8 * 5000);
		fail_count++;
		wrap_up();
	end
	// stage timing, then random start and enable levels
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		start_in <= 8'hd0;
		for (int k = 0; k < 4; k++) begin
			n = 0;
			while (oe_n[k] !== 1'b0 && n < 99) begin
				@(negedge ref_clk);
				n++;
			end
			if (k == 0)
				`CHK("first", 1'b1, n <= 4)
			else
				`CHK("lag", 1'b1, n >= D + 1 && n <= D + 2)
		end
		$display("stage timing done");
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			@(posedge ref_clk);
			start_in <= {seed[8] ? 2'b11 : seed[7:6], seed[5:0]};
			chain_in <= seed[11:9] | {3{seed[12]}};
			settle_check();
		end
		$display("random levels done");
		wrap_up();
	end
endmodule : test_power_good_sequencer
bind power_good_sequencer pg_seq_chk pg_seq_chk_i (.ref_clk(ref_clk),
	.rst(rst), .start_in(start_in), .chain_in(chain_in),
	.gate_drive(gate_drive), .supply_ok_oe_n(supply_ok_oe_n));
`default_nettype wire
